// ==== shared/sdl_regs.svh ====
/*
 * Register offsets, field positions, reset values and fixed counts of the
 * serial DAC load and readback front end.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef SDL_REGS_SVH
`define SDL_REGS_SVH

// ****************************************************************
// Register map (byte addresses on the AXI4-Lite bus).
// ****************************************************************
`define SDL_AXI_AW 8
`define SDL_OFS_CTRL 8'h00
`define SDL_OFS_STATUS 8'h04
`define SDL_OFS_DAC 8'h08
`define SDL_OFS_SHIFT 8'h0c

// ****************************************************************
// Field positions.
// ****************************************************************
`define SDL_CTRL_ENABLE 0
`define SDL_ST_IN_FRAME 0
`define SDL_ST_PENDING 1
`define SDL_ST_AUTO 2
`define SDL_ST_READBACK 3
`define SDL_ST_GROUND 4
`define SDL_ST_POWER_DOWN 5
`define SDL_ST_BUF_FULL 6

// ****************************************************************
// Reset values and counts.
// ****************************************************************
`define SDL_CTRL_RESET 1'b1
`define SDL_MID_12 16'h0800
`define SDL_MID_14 16'h2000
`define SDL_WORD_BITS 5'h10
`define SDL_PIN_IDLE 7'h7b
`define SDL_RESP_OKAY 2'b00
`define SDL_RESP_SLVERR 2'b10

`endif

// ==== shared/sdl_pkg.sv ====
/*
 * Types shared by the serial DAC front end: the frame state and the
 * packed state record of the main module.
 * Assumes the includer uses every name with the package prefix.
 */
package sdl_pkg;

    // One-hot frame states.
    typedef enum logic [2:0] {
        SDL_IDLE = 3'b001,
        SDL_SHIFTING = 3'b010,
        SDL_WAIT_LOAD = 3'b100
    } sdl_frame_t;

    // Whole state of the main module.
    typedef struct packed {
        sdl_frame_t fst;
        logic pend_auto;
        logic [4:0] bits;
        logic [15:0] shift;
        logic [15:0] dac;
        logic serial_out;
        logic rb_taken;
        logic sclk_q;
        logic frame_q;
        logic ground_sel;
        logic pd_flag;
        logic enable;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sdl_state_t;

endpackage

// ==== core/sdl_sync.sv ====
/*
 * Two flip-flop synchroniser for a group of pins.
 * Assumes each bit is an independent level; nothing reads the first stage.
 */
`timescale 1ns/1ps

module sdl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Pins in and their synchronised copy.
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);

    // Both stages held in one record.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sdl_sync_st_t;

    sdl_sync_st_t st_r; // Registered stages.
    sdl_sync_st_t st_nxt; // Next stages.

    // Shift each pin one stage along.
    always_comb begin
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
    end

    // Register the stages; reset to the idle pin levels.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= {RST_VAL, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.s2;

endmodule

// ==== core/sdl_fifo.sv ====
/*
 * Small valid/ready buffer for loaded DAC codes.
 * Assumes the writer holds data while in_ready is low.
 */
`timescale 1ns/1ps

module sdl_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // Storage, pointers and fill count as one record.
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } sdl_fifo_st_t;

    sdl_fifo_st_t st_r; // Registered buffer.
    sdl_fifo_st_t st_nxt; // Next buffer.
    logic push; // A word enters.
    logic pop; // A word leaves.

    assign in_ready = (st_r.cnt != CW'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data = st_r.mem[st_r.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Advance pointers and count on each transfer.
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == PW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == PW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    // Register the buffer; empty after reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

// ==== core/sdl_core.sv ====
/*
 * Digital front end of a single-channel serial-input DAC: serial shift
 * register, DAC register with load control, readback and daisy-chain
 * output, clear and power-down control, AXI4-Lite status/control port.
 * Assumes all pins come from outside the aclk domain, and that the pin
 * serial clock is slow enough (125 ns period) to be edge-sampled at aclk.
 */
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sdl_regs.svh"

module sdl_core #(
    parameter int DATA_W = 14,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Serial link pins.
    input wire logic sclk,
    input wire logic frame_n,
    input wire logic serial_in,
    input wire logic load_strobe_n,
    input wire logic readback_enable_n,
    output logic serial_out_o,
    output logic serial_out_oe,
    // Control pins.
    input wire logic output_clear_n,
    input wire logic power_down_n,
    // Analog stage controls.
    output logic [15:0] dac_code_o,
    output logic ground_sense_sel_o,
    output logic power_down_o,
    // Stream of loaded codes.
    output logic code_valid,
    input wire logic code_ready,
    output logic [15:0] code_data,
    // AXI4-Lite slave.
    input wire logic [`SDL_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SDL_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************************************
    // Constants and declarations.
    // ****************************************************************
    localparam logic [15:0] MID = (DATA_W == 14) ? `SDL_MID_14 : `SDL_MID_12;
    localparam logic [15:0] DMASK = 16'((32'h1 << DATA_W) - 1);

    sdl_pkg::sdl_state_t r; // Registered state; fields end _r in spirit.
    sdl_pkg::sdl_state_t r_nxt; // Next state.
    logic [6:0] pins_s; // Synchronised pins.
    logic sclk_s; // Synchronised serial clock.
    logic frame_s; // Synchronised frame strobe, low inside a frame.
    logic sin_s; // Synchronised serial data.
    logic load_strobe_n_s; // Synchronised load strobe.
    logic readback_enable_n_s; // Synchronised readback enable.
    logic clr_s; // Synchronised clear.
    logic pd_s; // Synchronised power-down.
    logic sclk_fall; // Falling serial clock edge seen.
    logic frame_fall; // Frame opens.
    logic frame_rise; // Frame closes.
    logic rb_xfer; // DAC register moves into the shift register.
    logic shift_ev; // A bit shifts through.
    logic load_go; // DAC register takes the shift register.
    logic buf_ready; // Buffer can take a code.
    logic [15:0] load_word; // Code that a load stores.

    // ****************************************************************
    // Pin synchronisation and edge detection.
    // ****************************************************************
    sdl_sync #(.W(7), .RST_VAL(`SDL_PIN_IDLE)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_i({power_down_n, output_clear_n, readback_enable_n, load_strobe_n, serial_in, frame_n, sclk}),
        .sync_o(pins_s)
    );

    assign {pd_s, clr_s, readback_enable_n_s, load_strobe_n_s, sin_s, frame_s, sclk_s} = pins_s;
    assign sclk_fall = r.sclk_q & ~sclk_s;
    assign frame_fall = r.frame_q & ~frame_s;
    assign frame_rise = ~r.frame_q & frame_s;
    assign rb_xfer = sclk_fall & ~readback_enable_n_s & ~r.rb_taken;
    // Bits move only on falls, and only inside a frame or a readback.
    assign shift_ev = sclk_fall & ~rb_xfer & ((r.fst == sdl_pkg::SDL_SHIFTING) | r.rb_taken);
    assign load_word = r.shift & DMASK;
    // A pending word loads when the buffer has room: at once if the strobe was low at frame start, else on strobe low.
    assign load_go = (r.fst == sdl_pkg::SDL_WAIT_LOAD) & (r.pend_auto | ~load_strobe_n_s) & buf_ready;

    // ****************************************************************
    // Code buffer: a stalled consumer holds back further loads.
    // ****************************************************************
    sdl_fifo #(.W(16), .DEPTH(BUF_DEPTH)) u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(load_go),
        .in_ready(buf_ready),
        .in_data(load_word),
        .out_valid(code_valid),
        .out_ready(code_ready),
        .out_data(code_data)
    );

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        r_nxt = r;
        r_nxt.sclk_q = sclk_s;
        r_nxt.frame_q = frame_s;
        // Clear only steers the output; registers keep their values.
        r_nxt.ground_sel = ~clr_s;
        r_nxt.pd_flag = ~pd_s;
        if (readback_enable_n_s) begin
            r_nxt.rb_taken = 1'b0;
        end
        // Serial shifting, readback and daisy-chain output.
        if (rb_xfer) begin
            r_nxt.shift = {r.dac[14:0], 1'b0};
            r_nxt.serial_out = r.dac[15];
            r_nxt.rb_taken = 1'b1;
        end else if (shift_ev) begin
            r_nxt.serial_out = r.shift[15];
            r_nxt.shift = {r.shift[14:0], sin_s};
            if (r.bits != `SDL_WORD_BITS) begin
                r_nxt.bits = r.bits + 5'h01;
            end
        end
        // Load of the DAC register.
        if (load_go) begin
            r_nxt.dac = load_word;
            r_nxt.fst = sdl_pkg::SDL_IDLE;
        end
        // Frame state machine.
        case (r.fst)
            sdl_pkg::SDL_IDLE, sdl_pkg::SDL_WAIT_LOAD: begin
                // A new frame starts a word and samples the load strobe.
                if (frame_fall && r.enable) begin
                    r_nxt.fst = sdl_pkg::SDL_SHIFTING;
                    r_nxt.bits = '0;
                    r_nxt.pend_auto = ~load_strobe_n_s;
                end
            end
            sdl_pkg::SDL_SHIFTING: begin
                // Only a full word is kept for loading.
                if (frame_rise) begin
                    r_nxt.fst = (r.bits == `SDL_WORD_BITS) ? sdl_pkg::SDL_WAIT_LOAD : sdl_pkg::SDL_IDLE;
                end
            end
            default: begin
                r_nxt.fst = sdl_pkg::SDL_IDLE;
            end
        endcase
        // AXI write: address and data taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            r_nxt.aw_got = 1'b1;
            r_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_nxt.w_got = 1'b1;
            r_nxt.wdata = s_axi_wdata;
            r_nxt.wstrb = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            r_nxt.aw_got = 1'b0;
            r_nxt.w_got = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = `SDL_RESP_OKAY;
            case (r.awaddr)
                `SDL_OFS_CTRL: begin
                    if (r.wstrb[0]) begin
                        r_nxt.enable = r.wdata[`SDL_CTRL_ENABLE];
                    end
                end
                `SDL_OFS_STATUS, `SDL_OFS_DAC, `SDL_OFS_SHIFT: begin
                    r_nxt.bresp = `SDL_RESP_OKAY;
                end
                default: begin
                    r_nxt.bresp = `SDL_RESP_SLVERR;
                end
            endcase
        end
        if (r.bvalid && s_axi_bready) begin
            r_nxt.bvalid = 1'b0;
        end
        // AXI read: one cycle from address to data.
        if (s_axi_arvalid && s_axi_arready) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp = `SDL_RESP_OKAY;
            r_nxt.rdata = '0;
            case (s_axi_araddr)
                `SDL_OFS_CTRL: begin
                    r_nxt.rdata[`SDL_CTRL_ENABLE] = r.enable;
                end
                `SDL_OFS_STATUS: begin
                    r_nxt.rdata[`SDL_ST_IN_FRAME] = (r.fst == sdl_pkg::SDL_SHIFTING);
                    r_nxt.rdata[`SDL_ST_PENDING] = (r.fst == sdl_pkg::SDL_WAIT_LOAD);
                    r_nxt.rdata[`SDL_ST_AUTO] = r.pend_auto;
                    r_nxt.rdata[`SDL_ST_READBACK] = r.rb_taken;
                    r_nxt.rdata[`SDL_ST_GROUND] = r.ground_sel;
                    r_nxt.rdata[`SDL_ST_POWER_DOWN] = r.pd_flag;
                    r_nxt.rdata[`SDL_ST_BUF_FULL] = ~buf_ready;
                end
                `SDL_OFS_DAC: begin
                    r_nxt.rdata[15:0] = r.dac;
                end
                `SDL_OFS_SHIFT: begin
                    r_nxt.rdata[15:0] = r.shift;
                end
                default: begin
                    r_nxt.rresp = `SDL_RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            r_nxt.rvalid = 1'b0;
        end
    end

    // ****************************************************************
    // State register; reset loads midscale into both data registers.
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.fst <= sdl_pkg::SDL_IDLE;
            r.shift <= MID;
            r.dac <= MID;
            r.serial_out <= 1'b1;
            r.frame_q <= 1'b1;
            r.enable <= `SDL_CTRL_RESET;
        end else begin
            r <= r_nxt;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign serial_out_o = 1'b0;
    assign serial_out_oe = ~r.serial_out;
    assign dac_code_o = r.dac;
    assign ground_sense_sel_o = r.ground_sel;
    assign power_down_o = r.pd_flag;
    assign s_axi_awready = ~r.aw_got & ~r.bvalid;
    assign s_axi_wready = ~r.w_got & ~r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = ~r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_MIDSCALE_AT_RESET: assert property ($rose(aresetn) |-> r.dac == MID && r.shift == MID)
        else $error("DAC register not midscale after reset");
    AST_SHIFT_ON_FALL: assert property (shift_ev |=> r.shift == {$past(r.shift[14:0]), $past(sin_s)})
        else $error("Serial bit not shifted on a falling edge");
    AST_NO_SHIFT_OFF_FALL: assert property (!sclk_fall |=> $stable(r.shift))
        else $error("Shift register moved without a falling edge");
    AST_IDLE_IGNORES_CLOCK: assert property (r.fst != sdl_pkg::SDL_SHIFTING && !r.rb_taken && readback_enable_n_s |=> $stable(r.shift))
        else $error("Shift register moved outside a frame");
    AST_SHORT_FRAME_DROPPED: assert property (frame_rise && r.fst == sdl_pkg::SDL_SHIFTING
        && r.bits != `SDL_WORD_BITS |=> r.fst == sdl_pkg::SDL_IDLE)
        else $error("Incomplete word kept for loading");
    AST_AUTO_LOAD: assert property (r.fst == sdl_pkg::SDL_WAIT_LOAD && r.pend_auto && buf_ready
        |=> r.dac == ($past(r.shift) & DMASK))
        else $error("Word not loaded at frame end with strobe low");
    AST_STROBE_LOAD: assert property (r.fst == sdl_pkg::SDL_WAIT_LOAD && !r.pend_auto && !load_strobe_n_s && buf_ready
        |=> r.dac == ($past(r.shift) & DMASK))
        else $error("Load strobe did not load the DAC register");
    AST_DEFERRED: assert property (r.fst == sdl_pkg::SDL_WAIT_LOAD && !r.pend_auto && load_strobe_n_s |=> $stable(r.dac))
        else $error("Deferred word loaded without the strobe");
    AST_DAISY_DELAY: assert property (shift_ev ##1 (!sclk_fall [*2]) |-> serial_out_oe == !$past(r.shift[15], 2))
        else $error("Daisy-chain output not the bit sixteen clocks old");
    AST_READBACK_MSB: assert property (rb_xfer |=> r.serial_out == $past(r.dac[15]) && r.shift[15:1] == $past(r.dac[14:0]))
        else $error("Readback did not present the DAC register");
    AST_CODE_WIDTH: assert property ((r.dac & ~DMASK) == 16'h0000)
        else $error("DAC register holds bits above the code width");
    AST_CLEAR: assert property ($fell(clr_s) |=> ground_sense_sel_o && ($stable(r.dac) || $past(load_go)))
        else $error("Clear did not select ground sense");
    AST_UNCLEAR: assert property ($rose(clr_s) |=> !ground_sense_sel_o && ($stable(dac_code_o) || $past(load_go)))
        else $error("Output stayed cleared after clear released");
    AST_POWER_DOWN: assert property ($fell(pd_s) |=> power_down_o [*2])
        else $error("Power-down input not followed");

endmodule

// ==== tb/sdl_host_model.sv ====
/*
 * Host serial port model: sends framed 16-bit words or bare clock bursts
 * and samples the device's open-drain output after each clock fall.
 * Assumes an external pull-up on the output pin and a 125 ns link clock.
 */
`timescale 1ns/1ps

module sdl_host_model (
    // Pins toward the device.
    output logic sclk,
    output logic frame_n,
    output logic serial_in,
    // Open-drain output of the device.
    input wire logic serial_out_o,
    input wire logic serial_out_oe
);
    // Pin level: driven low when enabled, otherwise the pull-up wins.
    wire logic sdo_pin = serial_out_oe ? serial_out_o : 1'b1;

    // The link stands still with the clock high and no frame open.
    initial begin
        sclk = 1'b1;
        frame_n = 1'b1;
        serial_in = 1'b0;
    end

    // Sends one word MSB first; q collects the output level after each fall.
    task automatic xfer(input logic [15:0] d, input logic framed, output logic [15:0] q);
        frame_n = !framed;
        for (int i = 15; i >= 0; i--) begin
            serial_in = d[i];
            #62.5;
            sclk = 1'b0;
            #62.5;
            q[i] = sdo_pin;
            sclk = 1'b1;
        end
        #62.5;
        frame_n = 1'b1;
        serial_in = !serial_in;
        #62.5;
    endtask
endmodule

// ==== tb/serial_dac_load_readback_tb.sv ====
/*
 * Self-checking bench of the serial DAC front end: AXI4-Lite register
 * tasks, frames through the host model and a drain of the code stream.
 * Assumes sdl_core with its defaults: 14-bit code, two-entry buffer.
 */
`timescale 1ns/1ps
`include "sdl_regs.svh"

module serial_dac_load_readback_tb;
    // Clock, reset, pins and bus signals.
    logic aclk = 1'b0, aresetn = 1'b0, load_strobe_n = 1'b0, readback_enable_n = 1'b1;
    logic output_clear_n = 1'b1, power_down_n = 1'b1, code_ready = 1'b0;
    wire logic sclk, frame_n, serial_in, serial_out_o, serial_out_oe, ground_sense_sel_o, power_down_o, code_valid;
    wire logic [15:0] dac_code_o, code_data;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    int fail_count = 0, n_compared = 0, cycles = 0;
    logic [15:0] q;
    logic [31:0] rd;
    logic [1:0] rs;

    // 250 MHz clock.
    always #2 aclk = ~aclk;

    sdl_core i_dut (.aclk, .aresetn, .sclk, .frame_n, .serial_in, .load_strobe_n, .readback_enable_n,
        .serial_out_o, .serial_out_oe, .output_clear_n, .power_down_n, .dac_code_o, .ground_sense_sel_o,
        .power_down_o, .code_valid, .code_ready, .code_data, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    sdl_host_model i_host (.sclk, .frame_n, .serial_in, .serial_out_o, .serial_out_oe);

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // AXI write: each channel is released at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (tb !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    // AXI read: rready stays high until the answer is sampled.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (tr !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // Waits a bounded time for the DAC register to reach a value.
    task automatic wait_dac(input logic [15:0] exp);
        for (int i = 0; i < 40 && dac_code_o !== exp; i++) @(negedge aclk);
        chk("dac_code", dac_code_o, exp);
    endtask

    // Checks the head of the code buffer, then takes it.
    task automatic pop(input logic [15:0] exp);
        @(negedge aclk);
        chk("code_head", {code_valid, code_data}, {1'b1, exp});
        @(posedge aclk) code_ready <= 1'b1;
        @(posedge aclk) code_ready <= 1'b0;
    endtask

    // A hang counts as a mismatch and ends the run.
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(negedge aclk);
        chk("dac_reset", dac_code_o, 16'h2000);
        rd_reg(`SDL_OFS_SHIFT, rd, rs);
        chk("shift_reset", rd, 32'h2000);
        rd_reg(`SDL_OFS_CTRL, rd, rs);
        chk("ctrl_reset", rd, 32'h1);
        rd_reg(8'h10, rd, rs);
        chk("unmapped_rd", rs, `SDL_RESP_SLVERR);
        wr(8'h10, 32'h1, rs);
        chk("unmapped_wr", rs, `SDL_RESP_SLVERR);
        i_host.xfer(16'hffff, 1'b0, q);
        rd_reg(`SDL_OFS_SHIFT, rd, rs);
        chk("shift_idle", rd, 32'h2000);
        $display("done: reset and idle clock");
        i_host.xfer(16'hd234, 1'b1, q);
        chk("daisy_mid", q, 16'h2000);
        wait_dac(16'h1234);
        @(posedge aclk) load_strobe_n <= 1'b1;
        repeat (4) @(posedge aclk);
        i_host.xfer(16'h0abc, 1'b1, q);
        chk("daisy_word", q, 16'hd234);
        repeat (10) @(negedge aclk);
        chk("dac_held", dac_code_o, 16'h1234);
        @(posedge aclk) load_strobe_n <= 1'b0;
        wait_dac(16'h0abc);
        wr(`SDL_OFS_CTRL, 32'h0, rs);
        i_host.xfer(16'h0555, 1'b1, q);
        repeat (10) @(negedge aclk);
        chk("dac_disabled", dac_code_o, 16'h0abc);
        wr(`SDL_OFS_CTRL, 32'h1, rs);
        $display("done: loads");
        rd_reg(`SDL_OFS_STATUS, rd, rs);
        chk("buf_full", rd[`SDL_ST_BUF_FULL], 1'b1);
        i_host.xfer(16'h0111, 1'b1, q);
        repeat (10) @(negedge aclk);
        chk("load_waits", dac_code_o, 16'h0abc);
        pop(16'h1234);
        wait_dac(16'h0111);
        pop(16'h0abc);
        pop(16'h0111);
        @(negedge aclk);
        chk("buf_empty", code_valid, 1'b0);
        $display("done: code buffer");
        @(posedge aclk) readback_enable_n <= 1'b0;
        i_host.xfer(16'h0000, 1'b0, q);
        @(posedge aclk) readback_enable_n <= 1'b1;
        chk("readback", q, 16'h0111);
        chk("sdo_drive", {serial_out_o, serial_out_oe}, 2'b00);
        @(posedge aclk);
        output_clear_n <= 1'b0;
        power_down_n <= 1'b0;
        repeat (6) @(negedge aclk);
        chk("cleared", ground_sense_sel_o, 1'b1);
        chk("pd_on", power_down_o, 1'b1);
        chk("dac_kept", dac_code_o, 16'h0111);
        @(posedge aclk);
        output_clear_n <= 1'b1;
        power_down_n <= 1'b1;
        repeat (6) @(negedge aclk);
        chk("uncleared", {ground_sense_sel_o, power_down_o, dac_code_o}, {2'b00, 16'h0111});
        $display("done: readback, clear, power down");
        close_out();
    end
endmodule
